// File: inc/sat_arith_pkg.sv
// Shared constants, operation codes and carriers of the saturating arithmetic unit
package sat_arith_pkg;

  localparam int WORD_W  = 32;
  localparam int HALF_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int WIDE_W  = 64;
  localparam int POS_W   = 6;
  localparam int SHAMT_W = 5;
  localparam int N_HALF  = WORD_W / HALF_W;
  localparam int N_BYTE  = WORD_W / BYTE_W;

  // Reset values of the unit's own state
  localparam logic              Q_RESET      = 1'h0;
  localparam logic [WORD_W-1:0] RESULT_RESET = 32'h0000_0000;

  // Operation selector, one code per instruction form
  typedef enum logic [3:0] {
    OP_SIGNED_WORD_CLAMP        = 4'h0,
    OP_UNSIGNED_WORD_CLAMP      = 4'h1,
    OP_SIGNED_DUAL_HALF_CLAMP   = 4'h2,
    OP_UNSIGNED_DUAL_HALF_CLAMP = 4'h3,
    OP_SAT_WORD_ADD             = 4'h4,
    OP_SAT_WORD_SUB             = 4'h5,
    OP_SAT_QUAD_BYTE_ADD        = 4'h6,
    OP_SAT_QUAD_BYTE_SUB        = 4'h7,
    OP_SAT_DUAL_HALF_ADD        = 4'h8,
    OP_SAT_DUAL_HALF_SUB        = 4'h9,
    OP_SAT_ADD_SUB_EXCHANGE     = 4'hA,
    OP_SAT_SUB_ADD_EXCHANGE     = 4'hB,
    OP_SAT_DOUBLING_ADD         = 4'hC,
    OP_SAT_DOUBLING_SUB         = 4'hD
  } op_type;

  // One issued operation from the decoder and register file
  typedef struct packed {
    logic                valid;
    op_type              op;
    logic                cond_pass;
    logic [WORD_W-1:0]   opa;
    logic [WORD_W-1:0]   opb;
    logic [POS_W-1:0]    sat_pos;
    logic                shift_left;
    logic [SHAMT_W-1:0]  shift_amt;
  } req_type;

  // Writeback towards the register file
  typedef struct packed {
    logic              dest_we;
    logic [WORD_W-1:0] data;
  } wb_type;

endpackage : sat_arith_pkg

// File: src/saturating_arith_unit.sv
// Saturating arithmetic datapath with sticky saturation flag
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] Signed word clamp: shift, then signed n-bit clamp
// [RULE2] Unsigned word clamp: shift, clamp below 2^(n-1)
// [RULE3] Any clamping sets sticky saturation flag; byte, half and exchange lane forms here clamp without setting it
// [RULE4] Condition flags are never modified
// [RULE5] Software never names stack pointer or program counter
// [RULE6] Signed dual half clamp accepts positions 1-16
// [RULE7] Unsigned dual half clamp accepts positions 0-15
// [RULE8] Signed halves clamped independently to n bits
// [RULE9] Unsigned halves clamped independently to n bits
// [RULE10] Word add/sub clamped to signed 32 bits
// [RULE11] Four byte lanes clamped to signed 8 bits
// [RULE12] Two half lanes clamped to signed 16 bits
// [RULE13] Byte and half lane forms never touch flag
// [RULE14] Flag holds unless clamping; arithmetic never clears
// [RULE15] Software clears flag only by status write
// [RULE16] Add-sub exchange: top add, bottom subtract, saturated
// [RULE17] Sub-add exchange: top subtract, bottom add, saturated
// [RULE18] Doubling add: saturate 2*b, add, saturate
// [RULE19] Doubling sub: saturate 2*b, subtract, saturate
// [RULE20] Either doubling or accumulate clamp sets flag
// [RULE21] Word clamp positions: signed 1-32, unsigned 0-31
// [RULE22] Shift is right arithmetic 1-31 or left 0-31
// [RULE23] Failed condition suppresses write and flag update
// [RULE24] Lanes use wide sums, no inter-lane carry
module saturating_arith_unit
  import sat_arith_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Issued operation
  input  wire req_type           i_req,
  // Status word write of the sticky flag
  input  wire logic              i_q_wr,
  input  wire logic              i_q_wdata,
  // Writeback and status
  output var  wb_type            o_wb,
  output var  logic              o_q_flag,
  output logic                   o_cond_flags_we
);

  // Clamp helper: returns {clamped, value}
  function automatic logic [WORD_W:0] clamp(input logic signed [WIDE_W-1:0] v,
                                            input logic signed [WIDE_W-1:0] hi,
                                            input logic signed [WIDE_W-1:0] lo);
    if (v > hi) begin
      clamp = {1'b1, hi[WORD_W-1:0]};
    end else if (v < lo) begin
      clamp = {1'b1, lo[WORD_W-1:0]};
    end else begin
      clamp = {1'b0, v[WORD_W-1:0]};
    end
  endfunction : clamp

  // Widen a 32-bit word with its sign
  function automatic logic signed [WIDE_W-1:0] sx(input logic [WORD_W-1:0] w);
    sx = {{(WIDE_W-WORD_W){w[WORD_W-1]}}, w};
  endfunction : sx

  logic                      fire;
  logic signed [WIDE_W-1:0]  one;
  logic [WORD_W-1:0]         shifted;
  logic signed [WIDE_W-1:0]  s_hi;
  logic signed [WIDE_W-1:0]  u_hi;
  logic [WORD_W:0]           word_s_clamp;
  logic [WORD_W:0]           word_u_clamp;
  logic [WORD_W:0]           word_add;
  logic [WORD_W:0]           word_sub;
  logic [WORD_W:0]           dbl;
  logic [WORD_W:0]           dbl_add;
  logic [WORD_W:0]           dbl_sub;
  logic [WORD_W-1:0]         half_s_res;
  logic [WORD_W-1:0]         half_u_res;
  logic [N_HALF-1:0]         half_s_hit;
  logic [N_HALF-1:0]         half_u_hit;
  logic [WORD_W-1:0]         half_add_res;
  logic [WORD_W-1:0]         half_sub_res;
  logic [WORD_W-1:0]         asx_res;
  logic [WORD_W-1:0]         sax_res;
  logic [WORD_W-1:0]         byte_add_res;
  logic [WORD_W-1:0]         byte_sub_res;
  logic [WORD_W-1:0]         nxt_result;
  logic                      sat_hit;

  // Operation takes effect only when issued with its condition true
  assign fire = i_req.valid & i_req.cond_pass; // RULE23
  assign one  = 64'sh0000_0000_0000_0001;

  // Pre-clamp shift; a right shift by zero is not encodable and acts as no shift
  always_comb begin
    if (i_req.shift_left) begin
      shifted = i_req.opa << i_req.shift_amt; // RULE22
    end else begin
      shifted = WORD_W'($signed(i_req.opa) >>> i_req.shift_amt); // RULE22
    end
  end

  // Word clamp bounds; position 0 on the unsigned form clamps everything to zero
  assign s_hi = (one <<< (i_req.sat_pos - 6'h01)) - one; // RULE1 RULE21
  assign u_hi = ((one <<< i_req.sat_pos) >>> 1) - ((i_req.sat_pos != 6'h00) ? one : 64'sh0); // RULE2 RULE21

  assign word_s_clamp = clamp(sx(shifted), s_hi, -s_hi - one); // RULE1
  assign word_u_clamp = clamp(sx(shifted), u_hi, 64'sh0);      // RULE2

  // Word add and subtract, evaluated at 64 bits so overflow is visible
  assign word_add = clamp(sx(i_req.opa) + sx(i_req.opb), 64'sh7FFF_FFFF, -64'sh8000_0000); // RULE10
  assign word_sub = clamp(sx(i_req.opa) - sx(i_req.opb), 64'sh7FFF_FFFF, -64'sh8000_0000); // RULE10

  // Doubling step then accumulate step, each limited to signed 32 bits
  assign dbl     = clamp(sx(i_req.opb) <<< 1, 64'sh7FFF_FFFF, -64'sh8000_0000);                      // RULE18 RULE19
  assign dbl_add = clamp(sx(i_req.opa) + sx(dbl[WORD_W-1:0]), 64'sh7FFF_FFFF, -64'sh8000_0000); // RULE18
  assign dbl_sub = clamp(sx(i_req.opa) - sx(dbl[WORD_W-1:0]), 64'sh7FFF_FFFF, -64'sh8000_0000); // RULE19

  // Halfword lanes: 17-bit sums keep each lane's carry local
  for (genvar h = 0; h < N_HALF; h++) begin : g_half
    logic signed [HALF_W:0]   a_h;
    logic signed [HALF_W:0]   b_h;
    logic signed [HALF_W:0]   b_x;
    logic signed [HALF_W:0]   sum_h;
    logic signed [HALF_W:0]   dif_h;
    logic signed [HALF_W:0]   asx_h;
    logic signed [HALF_W:0]   sax_h;
    logic signed [HALF_W:0]   pos_hi;
    logic signed [HALF_W:0]   s_lim;
    logic signed [HALF_W:0]   u_lim;
    logic [WORD_W:0]          cs;
    logic [WORD_W:0]          cu;
    logic [WORD_W:0]          c_add;
    logic [WORD_W:0]          c_sub;
    logic [WORD_W:0]          c_asx;
    logic [WORD_W:0]          c_sax;

    assign a_h    = {i_req.opa[h*HALF_W+HALF_W-1], i_req.opa[h*HALF_W +: HALF_W]};
    assign b_h    = {i_req.opb[h*HALF_W+HALF_W-1], i_req.opb[h*HALF_W +: HALF_W]};
    // Opposite half of the second operand for the exchange forms
    assign b_x    = {i_req.opb[(N_HALF-1-h)*HALF_W+HALF_W-1], i_req.opb[(N_HALF-1-h)*HALF_W +: HALF_W]};
    assign sum_h  = a_h + b_h; // RULE24
    assign dif_h  = a_h - b_h; // RULE24
    // Top lane (h=1) adds on exchange-add, bottom lane subtracts; reversed for sub-add
    assign asx_h  = (h == N_HALF - 1) ? a_h + b_x : a_h - b_x; // RULE16
    assign sax_h  = (h == N_HALF - 1) ? a_h - b_x : a_h + b_x; // RULE17
    assign pos_hi = 17'sh07FFF;
    assign s_lim  = (17'sh00001 <<< (i_req.sat_pos[4:0] - 5'h01)) - 17'sh00001; // RULE6
    assign u_lim  = (17'sh00001 <<< i_req.sat_pos[4:0]) - 17'sh00001;           // RULE7

    assign cs    = clamp(WIDE_W'(a_h), WIDE_W'(s_lim), WIDE_W'(-s_lim - 17'sh00001)); // RULE8
    assign cu    = clamp(WIDE_W'(a_h), WIDE_W'(u_lim), 64'sh0);                         // RULE9
    assign c_add = clamp(WIDE_W'(sum_h), WIDE_W'(pos_hi), WIDE_W'(-pos_hi - 17'sh00001)); // RULE12
    assign c_sub = clamp(WIDE_W'(dif_h), WIDE_W'(pos_hi), WIDE_W'(-pos_hi - 17'sh00001)); // RULE12
    assign c_asx = clamp(WIDE_W'(asx_h), WIDE_W'(pos_hi), WIDE_W'(-pos_hi - 17'sh00001)); // RULE16
    assign c_sax = clamp(WIDE_W'(sax_h), WIDE_W'(pos_hi), WIDE_W'(-pos_hi - 17'sh00001)); // RULE17

    assign half_s_res[h*HALF_W +: HALF_W]   = cs[HALF_W-1:0];
    assign half_u_res[h*HALF_W +: HALF_W]   = cu[HALF_W-1:0];
    assign half_s_hit[h]                    = cs[WORD_W];
    assign half_u_hit[h]                    = cu[WORD_W];
    assign half_add_res[h*HALF_W +: HALF_W] = c_add[HALF_W-1:0];
    assign half_sub_res[h*HALF_W +: HALF_W] = c_sub[HALF_W-1:0];
    assign asx_res[h*HALF_W +: HALF_W]      = c_asx[HALF_W-1:0];
    assign sax_res[h*HALF_W +: HALF_W]      = c_sax[HALF_W-1:0];
  end

  // Byte lanes: 9-bit sums, each lane saturates alone
  for (genvar b = 0; b < N_BYTE; b++) begin : g_byte
    logic signed [BYTE_W:0] a_b;
    logic signed [BYTE_W:0] b_b;
    logic [WORD_W:0]        c_add;
    logic [WORD_W:0]        c_sub;

    assign a_b   = {i_req.opa[b*BYTE_W+BYTE_W-1], i_req.opa[b*BYTE_W +: BYTE_W]};
    assign b_b   = {i_req.opb[b*BYTE_W+BYTE_W-1], i_req.opb[b*BYTE_W +: BYTE_W]};
    assign c_add = clamp(WIDE_W'(a_b + b_b), 64'sh7F, -64'sh80); // RULE11 RULE24
    assign c_sub = clamp(WIDE_W'(a_b - b_b), 64'sh7F, -64'sh80); // RULE11 RULE24
    assign byte_add_res[b*BYTE_W +: BYTE_W] = c_add[BYTE_W-1:0];
    assign byte_sub_res[b*BYTE_W +: BYTE_W] = c_sub[BYTE_W-1:0];
  end

  // Result select and flag-raising cause; lane forms contribute no cause
  always_comb begin
    nxt_result = RESULT_RESET;
    sat_hit    = 1'b0;
    case (i_req.op)
      OP_SIGNED_WORD_CLAMP: begin
        nxt_result = word_s_clamp[WORD_W-1:0];
        sat_hit    = word_s_clamp[WORD_W]; // RULE3
      end
      OP_UNSIGNED_WORD_CLAMP: begin
        nxt_result = word_u_clamp[WORD_W-1:0];
        sat_hit    = word_u_clamp[WORD_W]; // RULE3
      end
      OP_SIGNED_DUAL_HALF_CLAMP: begin
        nxt_result = half_s_res;
        sat_hit    = |half_s_hit; // RULE3
      end
      OP_UNSIGNED_DUAL_HALF_CLAMP: begin
        nxt_result = half_u_res;
        sat_hit    = |half_u_hit; // RULE3
      end
      OP_SAT_WORD_ADD: begin
        nxt_result = word_add[WORD_W-1:0];
        sat_hit    = word_add[WORD_W]; // RULE3
      end
      OP_SAT_WORD_SUB: begin
        nxt_result = word_sub[WORD_W-1:0];
        sat_hit    = word_sub[WORD_W]; // RULE3
      end
      OP_SAT_QUAD_BYTE_ADD:    nxt_result = byte_add_res; // RULE13
      OP_SAT_QUAD_BYTE_SUB:    nxt_result = byte_sub_res; // RULE13
      OP_SAT_DUAL_HALF_ADD:    nxt_result = half_add_res; // RULE13
      OP_SAT_DUAL_HALF_SUB:    nxt_result = half_sub_res; // RULE13
      OP_SAT_ADD_SUB_EXCHANGE: nxt_result = asx_res;
      OP_SAT_SUB_ADD_EXCHANGE: nxt_result = sax_res;
      OP_SAT_DOUBLING_ADD: begin
        nxt_result = dbl_add[WORD_W-1:0];
        sat_hit    = dbl[WORD_W] | dbl_add[WORD_W]; // RULE20
      end
      OP_SAT_DOUBLING_SUB: begin
        nxt_result = dbl_sub[WORD_W-1:0];
        sat_hit    = dbl[WORD_W] | dbl_sub[WORD_W]; // RULE20
      end
      default: begin
        nxt_result = RESULT_RESET;
        sat_hit    = 1'b0;
      end
    endcase
  end

  // Writeback register; data holds between operations
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb <= '{dest_we: 1'b0, data: RESULT_RESET};
    end else begin
      o_wb.dest_we <= fire; // RULE23
      if (fire) begin
        o_wb.data <= nxt_result;
      end
    end
  end

  // Sticky flag: a clamp in the same cycle as a status write wins, so no event is lost
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_q_flag <= Q_RESET;
    end else if (fire && sat_hit) begin
      o_q_flag <= 1'b1; // RULE3 RULE20
    end else if (i_q_wr) begin // RULE14
      o_q_flag <= i_q_wdata; // RULE15
    end
  end

  // The unit owns no path to the condition flags
  assign o_cond_flags_we = 1'b0; // RULE4

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_q_set_clamp: assert property (fire && sat_hit |=> o_q_flag) // RULE3
    else $error("clamp did not set sticky flag");
  a_q_sticky_hold: assert property (o_q_flag && !i_q_wr |=> o_q_flag) // RULE14
    else $error("sticky flag dropped without status write");
  a_lane_no_flag: assert property (fire && !i_q_wr && (i_req.op inside {OP_SAT_QUAD_BYTE_ADD, OP_SAT_QUAD_BYTE_SUB,
      OP_SAT_DUAL_HALF_ADD, OP_SAT_DUAL_HALF_SUB}) |=> $stable(o_q_flag)) // RULE13
    else $error("lane operation changed sticky flag");
  a_cond_false_quiet: assert property (i_req.valid && !i_req.cond_pass && !i_q_wr
      |=> !o_wb.dest_we && $stable(o_q_flag) && $stable(o_wb.data)) // RULE23
    else $error("failed condition still wrote");
  a_ssat8_range: assert property (fire && i_req.op == OP_SIGNED_WORD_CLAMP && i_req.sat_pos == 6'h08
      |=> ($signed(o_wb.data) <= 32'sh7F) && ($signed(o_wb.data) >= -32'sh80)) // RULE1
    else $error("signed word clamp out of 8-bit range");
  a_unsigned_word_clamp_nonneg: assert property (fire && i_req.op == OP_UNSIGNED_WORD_CLAMP |=> !o_wb.data[WORD_W-1]) // RULE2
    else $error("unsigned word clamp negative");
  a_word_add_pos: assert property (fire && i_req.op == OP_SAT_WORD_ADD && !i_req.opa[WORD_W-1]
      && !i_req.opb[WORD_W-1] |=> !o_wb.data[WORD_W-1]) // RULE10
    else $error("positive word sum wrapped");
  a_byte_lane_pos: assert property (fire && i_req.op == OP_SAT_QUAD_BYTE_ADD && !i_req.opa[BYTE_W-1]
      && !i_req.opb[BYTE_W-1] |=> !o_wb.data[BYTE_W-1]) // RULE11
    else $error("positive byte sum wrapped");
  // A negative first operand pulls the sum back below the limit, so only a non-negative one pins it
  a_dbl_max: assert property (fire && i_req.op == OP_SAT_DOUBLING_ADD && i_req.opb == 32'h7FFF_FFFF
      && !i_req.opa[WORD_W-1] |=> o_wb.data == 32'h7FFF_FFFF && o_q_flag) // RULE20
    else $error("doubling clamp wrong");
  a_half_unsigned_word_clamp_pos: assert property (fire && i_req.op == OP_UNSIGNED_DUAL_HALF_CLAMP
      |=> !o_wb.data[HALF_W-1] && !o_wb.data[WORD_W-1]) // RULE9
    else $error("unsigned half clamp negative");

  // Exchange forms saturate per lane but, like the other lane forms, leave the flag alone
  a_exch_no_flag: assert property (fire && !i_q_wr && (i_req.op inside {OP_SAT_ADD_SUB_EXCHANGE,
      OP_SAT_SUB_ADD_EXCHANGE}) |=> $stable(o_q_flag)) // RULE16 RULE17
    else $error("exchange operation changed sticky flag");
  a_asx_top_pos: assert property (fire && i_req.op == OP_SAT_ADD_SUB_EXCHANGE && !i_req.opa[WORD_W-1]
      && !i_req.opb[HALF_W-1] |=> !o_wb.data[WORD_W-1]) // RULE16
    else $error("exchange top sum wrapped");
  a_sax_bot_pos: assert property (fire && i_req.op == OP_SAT_SUB_ADD_EXCHANGE && !i_req.opa[HALF_W-1]
      && !i_req.opb[WORD_W-1] |=> !o_wb.data[HALF_W-1]) // RULE17
    else $error("exchange bottom sum wrapped");

  // Halfword and byte lanes: the low lane must saturate rather than wrap its sign bit
  a_half_add_pos: assert property (fire && i_req.op == OP_SAT_DUAL_HALF_ADD && !i_req.opa[HALF_W-1]
      && !i_req.opb[HALF_W-1] |=> !o_wb.data[HALF_W-1]) // RULE12 RULE24
    else $error("positive half sum wrapped");
  a_half_sub_neg: assert property (fire && i_req.op == OP_SAT_DUAL_HALF_SUB && i_req.opa[HALF_W-1]
      && !i_req.opb[HALF_W-1] |=> o_wb.data[HALF_W-1]) // RULE12 RULE24
    else $error("negative half difference wrapped");
  a_byte_sub_neg: assert property (fire && i_req.op == OP_SAT_QUAD_BYTE_SUB && i_req.opa[BYTE_W-1]
      && !i_req.opb[BYTE_W-1] |=> o_wb.data[BYTE_W-1]) // RULE11 RULE24
    else $error("negative byte difference wrapped");

  // One signed bit leaves only zero or minus one in the low half
  a_half_s_one: assert property (fire && i_req.op == OP_SIGNED_DUAL_HALF_CLAMP && i_req.sat_pos == 6'h01
      |=> (o_wb.data[HALF_W-1:0] == 16'h0000) || (o_wb.data[HALF_W-1:0] == 16'hFFFF)) // RULE6 RULE8
    else $error("signed half clamp to one bit wrong");
  a_unsigned_word_clamp_zero: assert property (fire && i_req.op == OP_UNSIGNED_WORD_CLAMP && i_req.sat_pos == 6'h00
      |=> o_wb.data == 32'h0000_0000) // RULE21
    else $error("unsigned word clamp at position zero not zero");

  // Doubling subtract of the largest value always clamps in the doubling step
  a_dbl_sub_flag: assert property (fire && i_req.op == OP_SAT_DOUBLING_SUB && i_req.opb == 32'h7FFF_FFFF
      |=> o_q_flag) // RULE19 RULE20
    else $error("doubling subtract clamp did not set flag");

  // Writeback strobe follows each taken request by exactly one cycle
  a_wb_pulse: assert property (fire |=> o_wb.dest_we) // RULE23
    else $error("taken request gave no writeback");
  a_wb_quiet: assert property (!fire |=> !o_wb.dest_we) // RULE23
    else $error("writeback without a taken request");
  a_cond_flags_off: assert property (!o_cond_flags_we) // RULE4
    else $error("condition flag write raised");

  c_word_clamp: cover property (fire && i_req.op == OP_SIGNED_WORD_CLAMP && sat_hit);
  c_q_write_race: cover property (fire && sat_hit && i_q_wr && !i_q_wdata);
  c_doubling_sub: cover property (fire && i_req.op == OP_SAT_DOUBLING_SUB && dbl[WORD_W]);
  c_half_clamp: cover property (fire && i_req.op == OP_SIGNED_DUAL_HALF_CLAMP && sat_hit);
  c_cond_false: cover property (i_req.valid && !i_req.cond_pass);

endmodule : saturating_arith_unit
`default_nettype wire

// File: testbench/decoder_model.sv
// Behavioural issuing decoder and register file in front of the saturating unit
`timescale 1ns/1ps
`default_nettype none
module decoder_model (
  // Clock
  input  wire logic                   i_sys_clk,
  // Towards the unit
  output var  sat_arith_pkg::req_type o_req,
  output var  logic                   o_q_wr,
  output var  logic                   o_q_wdata
);
  // Issue one operation; operands only ever come from general registers
  task automatic issue(input sat_arith_pkg::req_type q);
    @(posedge i_sys_clk);
    o_req <= q;
  endtask : issue

  // Operand lines carry no data when idle, so scramble them
  task automatic idle();
    @(posedge i_sys_clk);
    o_req.valid <= 1'h0;
    o_req.opa   <= ~o_req.opa;
    o_req.opb   <= ~o_req.opb;
  endtask : idle

  // Explicit status-word write, the only way besides reset that the flag gets cleared
  task automatic q_write(input logic d);
    @(posedge i_sys_clk);
    o_q_wr    <= 1'h1;
    o_q_wdata <= d;
    @(posedge i_sys_clk);
    o_q_wr    <= 1'h0;
    o_q_wdata <= ~d;
  endtask : q_write

  // Quiet lines from time zero
  initial begin
    o_req     = '0;
    o_q_wr    = 1'h0;
    o_q_wdata = 1'h0;
  end
endmodule : decoder_model
`default_nettype wire

// File: testbench/saturating_arith_unit_tb_top.sv
// Self-checking bench of the saturating arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module saturating_arith_unit_tb_top;
  import sat_arith_pkg::*;
  typedef struct {logic [WORD_W-1:0] data; logic q;} exp_type;
  localparam longint MX = 64'sh0000_0000_7FFF_FFFF;
  logic              i_sys_clk, i_rst, i_q_wr, i_q_wdata, o_q_flag, o_cond_flags_we;
  req_type           i_req;
  wb_type            o_wb;
  exp_type           exp_q[$];
  int                failures = 0;
  int                n_compared = 0;
  logic              qm;
  logic [WORD_W-1:0] edges [6] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h7F80_807F,
                                   32'h8001_7FFF, 32'h0000_0001, 32'hFFFF_FFFF};

  decoder_model pm_u (.i_sys_clk(i_sys_clk), .o_req(i_req), .o_q_wr(i_q_wr), .o_q_wdata(i_q_wdata));
  saturating_arith_unit dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(i_req), .i_q_wr(i_q_wr),
    .i_q_wdata(i_q_wdata), .o_wb(o_wb), .o_q_flag(o_q_flag), .o_cond_flags_we(o_cond_flags_we));

  // 10 MHz core clock
  initial begin
    i_sys_clk = 1'h0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // Sign-extend the low w bits
  function automatic longint sx(input longint v, input int w);
    longint h;
    h = longint'(1) <<< (w - 1);
    return ((v & ((h <<< 1) - 1)) ^ h) - h;
  endfunction : sx

  // Clamp and remember whether the value changed
  function automatic longint clip(input longint v, input longint lo, input longint hi, inout bit c);
    c = c | (v < lo) | (v > hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clip

  // Reference result; lanes worked in 64 bits so no carry crosses a lane
  function automatic void ref_op(input req_type q, output logic [WORD_W-1:0] r, output bit c);
    longint x, rr, h, u, v;
    int n, w;
    bit dc, sb;
    c = 0;
    dc = 0;
    rr = 0;
    n = q.sat_pos;
    h = (n == 0) ? 0 : longint'(1) <<< (n - 1);
    x = q.shift_left ? sx(longint'(q.opa) << q.shift_amt, 32) : sx(longint'(q.opa), 32) >>> q.shift_amt;
    w = (q.op inside {OP_SAT_QUAD_BYTE_ADD, OP_SAT_QUAD_BYTE_SUB}) ? 8 : 16;
    case (q.op)
      OP_SIGNED_WORD_CLAMP:   rr = clip(x, -h, h - 1, c);
      OP_UNSIGNED_WORD_CLAMP: rr = clip(x, 0, (n == 0) ? 0 : h - 1, c);
      OP_SAT_WORD_ADD, OP_SAT_WORD_SUB: rr = clip(sx(q.opa, 32) + ((q.op == OP_SAT_WORD_SUB) ?
        -sx(q.opb, 32) : sx(q.opb, 32)), -MX - 1, MX, c);
      OP_SAT_DOUBLING_ADD, OP_SAT_DOUBLING_SUB: begin
        v = clip(2 * sx(q.opb, 32), -MX - 1, MX, c);
        rr = clip((q.op == OP_SAT_DOUBLING_SUB) ? sx(q.opa, 32) - v : sx(q.opa, 32) + v, -MX - 1, MX, c);
      end
      default: for (int k = 0; k < WORD_W / w; k++) begin
        sb = (q.op inside {OP_SAT_QUAD_BYTE_SUB, OP_SAT_DUAL_HALF_SUB}) ||
             (q.op == OP_SAT_ADD_SUB_EXCHANGE && k == 0) || (q.op == OP_SAT_SUB_ADD_EXCHANGE && k == 1);
        u = sx(longint'(q.opa) >> (k * w), w);
        v = sx(longint'(q.opb) >> (((q.op inside {OP_SAT_ADD_SUB_EXCHANGE, OP_SAT_SUB_ADD_EXCHANGE}) ?
          1 - k : k) * w), w);
        if (q.op == OP_SIGNED_DUAL_HALF_CLAMP) u = clip(u, -h, h - 1, c);
        else if (q.op == OP_UNSIGNED_DUAL_HALF_CLAMP) u = clip(u, 0, (longint'(1) <<< n) - 1, c);
        else u = clip(sb ? u - v : u + v, -(longint'(1) <<< (w - 1)), (longint'(1) <<< (w - 1)) - 1, dc);
        rr = rr | ((u & ((longint'(1) <<< w) - 1)) <<< (k * w));
      end
    endcase
    r = WORD_W'(rr);
  endfunction : ref_op

  // One comparison, four-state exact
  task automatic check(input string nm, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Flag set then cleared, then twelve back-to-back operations of one kind
  task automatic run_group(input op_type op);
    req_type q;
    logic [WORD_W-1:0] r;
    bit c;
    int nb[4] = '{1, 0, 1, 0};
    int ns[4] = '{32, 32, 16, 16};
    for (int d = 1; d >= 0; d--) begin
      pm_u.q_write(d[0]);
      #1;
      check("flag write", o_q_flag, d[0]);
      qm = d[0];
    end
    for (int i = 0; i < 12; i++) begin
      q.valid = 1'h1;
      q.op = op;
      q.cond_pass = ($urandom % 8) != 0;
      q.opa = (i < 6) ? edges[i] : $urandom;
      q.opb = (i < 6) ? edges[(i + 3) % 6] : $urandom;
      q.sat_pos = (op > 3) ? POS_W'($urandom) : (i == 0) ? POS_W'(nb[op] + ns[op] - 1) :
                  (i == 1) ? POS_W'(nb[op]) : POS_W'(nb[op] + $urandom % ns[op]);
      q.shift_left = $urandom % 2;
      q.shift_amt = q.shift_left ? SHAMT_W'($urandom % 32) : SHAMT_W'(1 + $urandom % 31);
      ref_op(q, r, c);
      // A failed condition leaves both result and flag alone
      if (q.cond_pass) begin
        qm = qm | c;
        exp_q.push_back('{r, qm});
      end
      pm_u.issue(q);
    end
    pm_u.idle();
  endtask : run_group

  // Watcher: every writeback takes the oldest note
  always @(posedge i_sys_clk) begin
    exp_type e;
    if (!i_rst) begin
      check("cond flags write", o_cond_flags_we, 1'h0);
      if (o_wb.dest_we === 1'h1) begin
        if (exp_q.size() == 0) check("spare write", 1'h1, 1'h0);
        else begin
          e = exp_q.pop_front();
          check("result", o_wb.data, e.data);
          check("result lanes", o_wb.data, e.data);
          check("flag", o_q_flag, e.q);
        end
      end
    end
  end

  // Watchdog well past the expected few hundred cycles
  initial begin
    #(100 * 20000);
    failures++;
    end_sim();
  end

  // Main sequence
  initial begin
    i_rst = 1'h1;
    void'($urandom(16));
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    @(posedge i_sys_clk);
    #1;
    check("reset data", o_wb.data, RESULT_RESET);
    check("reset flag", o_q_flag, Q_RESET);
    for (int op = 0; op < 14; op++) run_group(op_type'(op));
    pm_u.idle();
    pm_u.idle();
    check("notes left", exp_q.size(), 0);
    end_sim();
  end
endmodule : saturating_arith_unit_tb_top
`default_nettype wire
